/* plt_pkg.sv */
// Shared constants and types for the pixel lookup table block.
// Assumes a single 125 MHz clock and an AHB-Lite register bus.
package plt_pkg;

    // Clock and table geometry
    localparam int CLK_PERIOD_NS = 8;
    localparam int PIX_IN_W = 16;
    localparam int PIX_OUT_W = 16;
    localparam int IDX_W = 11;
    localparam int COEF_W = 9;
    localparam int TABLE_DEPTH = 2048;
    localparam logic [IDX_W-1:0] IDX_MAX = 11'h7FF;

    // Register offsets, byte addresses inside a 16 KiB window
    localparam int ADDR_W = 14;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 14'h0000;
    localparam logic [ADDR_W-1:0] OFF_SEL = 14'h0004;
    localparam logic [ADDR_W-1:0] OFF_IDX = 14'h0008;
    localparam logic [ADDR_W-1:0] OFF_VAL = 14'h000C;
    localparam logic [ADDR_W-1:0] OFF_STAT = 14'h0010;
    // Bulk window: entry i at 0x2000 + 4*i
    localparam int BULK_BIT = 13;

    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FMT_LSB = 1;
    localparam int FMT_W = 2;
    localparam int STAT_REJ_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int SEL_W = 8;

    // Output pixel formats
    typedef enum logic [FMT_W-1:0] {
        FMT_8 = 2'h0,
        FMT_12 = 2'h1,
        FMT_16 = 2'h2
    } plt_fmt_t;
    localparam logic [FMT_W-1:0] FMT_RSVD = 2'h3;

    // Reset values
    localparam logic CTRL_EN_RST = 1'b0;
    localparam plt_fmt_t CTRL_FMT_RST = FMT_8;
    localparam logic [SEL_W-1:0] SEL_USER_ONE = 8'h00;
    localparam logic [IDX_W-1:0] IDX_RST = 11'h000;

    // Default table load takes one cycle per entry
    localparam int INIT_CYCLES = TABLE_DEPTH;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACC,
        BUS_RD
    } plt_bus_st_t;

endpackage

/* plt_mem.sv */
// Coefficient store of the pixel lookup table.
// Port A serves the pixel stream, port B serves init and the bus.
// Both read ports are registered; a read beside a write returns old data.
module plt_mem
    import plt_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [IDX_W-1:0] a_addr_i,
    output logic [COEF_W-1:0] a_q_o,
    input wire logic [IDX_W-1:0] b_addr_i,
    input wire logic b_we_i,
    input wire logic [COEF_W-1:0] b_wdata_i,
    output logic [COEF_W-1:0] b_q_o
);

    // Volatile only: content is lost with power
    logic [COEF_W-1:0] mem [TABLE_DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (b_we_i) begin
            mem[b_addr_i] <= b_wdata_i;
        end
        b_q_o <= mem[b_addr_i];
        a_q_o <= mem[a_addr_i];
    end

endmodule

/* plt_lookup.sv */
// Pixel lookup table: remaps a pixel stream through one user table.
// Assumes the pixel stream and the AHB-Lite master share ref_clk_i.
// Behaviour
// - Each pixel indexes a table with 11 bits and yields 9 bits.
// - Input codes above 2047 saturate to 2047 before lookup.
// - 8-bit output drops the table result's least significant bit.
// - 12-bit output puts result in top nine bits, low three zero.
// - 16-bit output puts result in top nine bits, low seven zero.
// - The table may be used with every output format.
// - After power-on the table loads entry equal to index divided by four.
// - Only one user table exists; the selector offers only it.
// - Coefficient writes take effect at once, even while enabled.
// - Index picks an entry; value reads or replaces that entry.
// - Table applies only while enable is set; host enables after edits.
// - A bulk window reaches every coefficient without the index.
// - RGB and YUV channels all pass through the same table.
// - Mono and Bayer streams are treated as one channel.
// - Coefficients are volatile; reset restores the default table.
module plt_lookup
    import plt_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic pix_valid_i,
    input wire logic [PIX_IN_W-1:0] pix_data_i,
    output logic pix_valid_o,
    output logic [PIX_OUT_W-1:0] pix_data_o
);

    // Control and status state
    logic table_enable;
    plt_fmt_t out_fmt;
    logic [SEL_W-1:0] table_selector;
    logic [IDX_W-1:0] coefficient_index;
    logic idx_rejected;
    logic init_busy;
    logic [IDX_W-1:0] init_cnt;

    // Bus data-phase state
    plt_bus_st_t bus_st;
    logic [ADDR_W-1:0] d_addr;
    logic d_write;
    logic d_word;
    logic d_map;

    // Pixel pipeline stage
    logic s1_valid;
    logic s1_tab;
    plt_fmt_t s1_fmt;
    logic [IDX_W-1:0] s1_pix;

    // Memory ports
    logic [COEF_W-1:0] lut_qa;
    logic [COEF_W-1:0] lut_qb;
    wire logic [IDX_W-1:0] mem_b_addr;
    wire logic mem_b_we;
    wire logic [COEF_W-1:0] mem_b_wdata;

    // Bus decode
    wire logic addr_take = hsel_i && htrans_i[1] && hready_i &&
        (bus_st == BUS_IDLE);
    wire logic acc_go = (bus_st == BUS_ACC) && !init_busy;
    wire logic in_bulk = d_map && d_addr[BULK_BIT];
    wire logic in_regs = d_map && !d_addr[BULK_BIT];
    wire logic wr_ok = acc_go && d_write && d_word;
    wire logic wr_ctrl = wr_ok && in_regs && (d_addr == OFF_CTRL);
    wire logic wr_sel = wr_ok && in_regs && (d_addr == OFF_SEL);
    wire logic wr_idx = wr_ok && in_regs && (d_addr == OFF_IDX);
    wire logic wr_val = wr_ok && in_regs && (d_addr == OFF_VAL);
    wire logic wr_stat = wr_ok && in_regs && (d_addr == OFF_STAT);
    wire logic wr_bulk = wr_ok && in_bulk;
    wire logic idx_bad = (hwdata_i[31:IDX_W] != '0);
    wire logic [FMT_W-1:0] wr_fmt = hwdata_i[CTRL_FMT_LSB +: FMT_W];
    wire logic rej_set = wr_idx && idx_bad;
    wire logic rej_clr = wr_stat && hwdata_i[STAT_REJ_BIT];
    wire logic next_rej = rej_set || (idx_rejected && !rej_clr);

    // Port B: default load first, then index or bulk access
    assign mem_b_addr = init_busy ? init_cnt :
        (in_bulk ? d_addr[BULK_BIT-1:2] : coefficient_index);
    assign mem_b_we = init_busy || wr_val || wr_bulk;
    assign mem_b_wdata = init_busy ? init_cnt[IDX_W-1:2] :
        hwdata_i[COEF_W-1:0];

    // Register read selection, valid in BUS_RD
    wire logic [31:0] rd_ctrl = {29'h00000000, out_fmt, table_enable};
    wire logic [31:0] rd_sel = {24'h000000, table_selector};
    wire logic [31:0] rd_idx = {21'h000000, coefficient_index};
    wire logic [31:0] rd_coef = {23'h000000, lut_qb};
    wire logic [31:0] rd_stat = {30'h00000000, init_busy, idx_rejected};
    wire logic [31:0] rd_mux =
        in_bulk ? rd_coef :
        !in_regs ? 32'h00000000 :
        (d_addr == OFF_CTRL) ? rd_ctrl :
        (d_addr == OFF_SEL) ? rd_sel :
        (d_addr == OFF_IDX) ? rd_idx :
        (d_addr == OFF_VAL) ? rd_coef :
        (d_addr == OFF_STAT) ? rd_stat : 32'h00000000;

    // Pixel path: one lane; color samples arrive in turn on it
    wire logic over_max = pix_data_i > {5'h00, IDX_MAX};
    wire logic [IDX_W-1:0] sat_pix = over_max ? IDX_MAX :
        pix_data_i[IDX_W-1:0];
    wire logic use_tab = table_enable && !init_busy;
    wire logic [PIX_OUT_W-1:0] tab_val =
        (s1_fmt == FMT_8) ? {8'h00, lut_qa[COEF_W-1:1]} :
        (s1_fmt == FMT_12) ? {4'h0, lut_qa, 3'h0} :
        {lut_qa, 7'h00};
    wire logic [PIX_OUT_W-1:0] byp_val =
        (s1_fmt == FMT_8) ? {8'h00, s1_pix[IDX_W-1:3]} :
        (s1_fmt == FMT_12) ? {4'h0, s1_pix, 1'b0} :
        {s1_pix, 5'h00};
    // Format never gates the table choice
    wire logic [PIX_OUT_W-1:0] next_pix = s1_tab ? tab_val : byp_val;

    plt_mem u_mem (
        .ref_clk_i(ref_clk_i),
        .a_addr_i(sat_pix),
        .a_q_o(lut_qa),
        .b_addr_i(mem_b_addr),
        .b_we_i(mem_b_we),
        .b_wdata_i(mem_b_wdata),
        .b_q_o(lut_qb)
    );

    // Default table walk after every reset, one entry a cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            init_busy <= 1'b1;
            init_cnt <= IDX_RST;
        end else if (init_busy) begin
            init_cnt <= init_cnt + 1'b1;
            init_busy <= (init_cnt != IDX_MAX);
        end
    end

    // Bus slave: two wait states per transfer, more while the default table loads
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_st <= BUS_IDLE;
            hreadyout_o <= 1'b1;
            d_addr <= '0;
            d_write <= 1'b0;
            d_word <= 1'b0;
            d_map <= 1'b0;
        end else begin
            case (bus_st)
                BUS_IDLE: begin
                    if (addr_take) begin
                        bus_st <= BUS_ACC;
                        hreadyout_o <= 1'b0;
                        d_addr <= haddr_i[ADDR_W-1:0];
                        d_write <= hwrite_i;
                        d_word <= (hsize_i == 3'h2);
                        d_map <= (haddr_i[31:ADDR_W] == '0);
                    end
                end
                BUS_ACC: begin
                    // Held here while the default table loads
                    if (!init_busy) begin
                        bus_st <= BUS_RD;
                    end
                end
                BUS_RD: begin
                    bus_st <= BUS_IDLE;
                    hreadyout_o <= 1'b1;
                end
                default: begin
                    bus_st <= BUS_IDLE;
                    hreadyout_o <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hrdata_o <= 32'h00000000;
            hresp_o <= 1'b0;
        end else if (bus_st == BUS_RD) begin
            hrdata_o <= rd_mux;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            table_enable <= CTRL_EN_RST;
            out_fmt <= CTRL_FMT_RST;
        end else if (wr_ctrl) begin
            table_enable <= hwdata_i[CTRL_EN_BIT];
            if (wr_fmt != FMT_RSVD) begin
                out_fmt <= plt_fmt_t'(wr_fmt);
            end
        end
    end

    // Selector keeps its one legal choice; other codes are dropped
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            table_selector <= SEL_USER_ONE;
        end else if (wr_sel && hwdata_i[SEL_W-1:0] == SEL_USER_ONE) begin
            table_selector <= SEL_USER_ONE;
        end
    end

    // A rejected index leaves the old one in place and flags it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            coefficient_index <= IDX_RST;
            idx_rejected <= 1'b0;
        end else begin
            idx_rejected <= next_rej;
            if (wr_idx && !idx_bad) begin
                coefficient_index <= hwdata_i[IDX_W-1:0];
            end
        end
    end

    // Pixel pipeline, two cycles from input to output
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_tab <= 1'b0;
            s1_fmt <= FMT_8;
            s1_pix <= '0;
            pix_valid_o <= 1'b0;
            pix_data_o <= '0;
        end else begin
            s1_valid <= pix_valid_i;
            s1_tab <= use_tab;
            s1_fmt <= out_fmt;
            s1_pix <= sat_pix;
            pix_valid_o <= s1_valid;
            pix_data_o <= next_pix;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    // Stated on the raw upper bits so a broken compare cannot hide itself
    property p_saturate;
        pix_valid_i && pix_data_i[PIX_IN_W-1:IDX_W] != '0 |->
            sat_pix == IDX_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("Pixel above max not saturated");

    property p_out8;
        s1_valid && s1_tab && s1_fmt == FMT_8 |=>
            pix_valid_o && pix_data_o == {8'h00, $past(lut_qa[8:1])};
    endproperty
    a_out8: assert property (p_out8)
        else $error("8-bit output not truncated");

    property p_out12;
        s1_valid && s1_tab && s1_fmt == FMT_12 |=>
            pix_data_o == {4'h0, $past(lut_qa), 3'h0};
    endproperty
    a_out12: assert property (p_out12)
        else $error("12-bit output misplaced");

    property p_out16;
        s1_valid && s1_tab && s1_fmt == FMT_16 |=>
            pix_data_o == {$past(lut_qa), 7'h00};
    endproperty
    a_out16: assert property (p_out16)
        else $error("16-bit output misplaced");

    property p_bypass;
        pix_valid_i && !table_enable ##1 s1_fmt == FMT_16 |=>
            pix_valid_o && pix_data_o == {$past(sat_pix, 2), 5'h00};
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("Disabled table altered pixel");

    property p_init_step;
        init_busy |=> (init_busy && init_cnt == $past(init_cnt) + 11'h001)
            || ($past(init_cnt) == IDX_MAX && !init_busy);
    endproperty
    a_init_step: assert property (p_init_step)
        else $error("Default table walk skipped an entry");

    sequence s_coef_write;
        mem_b_we && !init_busy;
    endsequence
    sequence s_pix_same;
        pix_valid_i && sat_pix == $past(mem_b_addr);
    endsequence
    property p_write_now;
        s_coef_write ##1 s_pix_same |=> lut_qa == $past(mem_b_wdata, 2);
    endproperty
    a_write_now: assert property (p_write_now)
        else $error("Pixel missed fresh coefficient");

    property p_index_reject;
        rej_set |=> $stable(coefficient_index) && idx_rejected;
    endproperty
    a_index_reject: assert property (p_index_reject)
        else $error("Out-of-range index accepted");

    property p_selector;
        table_selector == SEL_USER_ONE;
    endproperty
    a_selector: assert property (p_selector)
        else $error("Selector left the only table");

    sequence s_fast_take;
        addr_take && !init_busy;
    endsequence
    property p_bus_wait;
        s_fast_take |=> !hreadyout_o [*2] ##1 hreadyout_o;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("Bus answer timing wrong");

    property p_value_read;
        bus_st == BUS_RD && !d_write && in_regs && d_addr == OFF_VAL |=>
            hrdata_o == {23'h000000, $past(lut_qb)};
    endproperty
    a_value_read: assert property (p_value_read)
        else $error("Value read returned wrong entry");

    property p_pix_latency;
        pix_valid_o == $past(pix_valid_i, 2);
    endproperty
    a_pix_latency: assert property (p_pix_latency)
        else $error("Pixel valid not two cycles after input");

    property p_enable_take;
        wr_ctrl |=> table_enable == $past(hwdata_i[CTRL_EN_BIT]);
    endproperty
    a_enable_take: assert property (p_enable_take)
        else $error("Enable write not taken");

endmodule

/* plt_pix_src.sv */
// Pixel source model standing in for the sensor pipeline.
// Assumes the bench asks for one sample per ref_clk_i rising edge.
module plt_pix_src
    import plt_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire logic [PIX_IN_W-1:0] code_i,
    output logic pix_valid_o,
    output logic [PIX_IN_W-1:0] pix_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle data toggles so a stale sample never looks like a fresh one
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pix_valid_o <= 1'b0;
            pix_data_o <= 16'h0000;
        end else begin
            pix_valid_o <= send_i;
            pix_data_o <= send_i ? code_i : ~pix_data_o;
        end
    end
endmodule

/* test_pixel_lookup_table.sv */
// Self-checking bench for the pixel lookup table over AHB-Lite.
// Assumes the pixel source model and one 125 MHz clock.
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end

module test_pixel_lookup_table
    import plt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TIMEOUT = 20000;
    logic ref_clk_i, rst_i, hsel, hwrite, send, en;
    logic hreadyout, hresp, pix_valid_in, pix_valid_out;
    logic [1:0] htrans, fmt;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [PIX_IN_W-1:0] code, pix_in;
    logic [PIX_OUT_W-1:0] pix_out;
    logic [COEF_W-1:0] tbl [TABLE_DEPTH];
    logic [PIX_OUT_W-1:0] exp_q [$];
    logic [PIX_OUT_W-1:0] exp_pix;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pts [5] = '{0, 3, 4, 1000, 2047};

    plt_lookup plt_lookup_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
        .pix_valid_i(pix_valid_in), .pix_data_i(pix_in),
        .pix_valid_o(pix_valid_out), .pix_data_o(pix_out)
    );

    plt_pix_src plt_pix_src_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .send_i(send),
        .code_i(code), .pix_valid_o(pix_valid_in), .pix_data_o(pix_in)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;
    end

    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Waits only on hready; the timeout below ends a hung wait
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk_i); while (hreadyout !== 1'b1);
        rdata = hrdata;
        `CHK(hresp, 1'b0)
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(rdata, e)
    endtask

    task automatic set_ctrl(input logic e, input logic [1:0] f);
        en = e;
        fmt = f;
        wr(32'(OFF_CTRL), {29'h0, f, e});
    endtask

    task automatic set_coef(input int i, input logic [8:0] v,
                            input logic bulk);
        tbl[i] = v;
        if (bulk)
            wr(32'h2000 + 32'(4 * i), {23'h0, v});
        else begin
            wr(32'(OFF_IDX), 32'(i));
            wr(32'(OFF_VAL), {23'h0, v});
        end
    endtask

    task automatic reset_model();
        for (int i = 0; i < TABLE_DEPTH; i++)
            tbl[i] = 9'(i / 4);
        en = 1'b0;
        fmt = 2'h0;
    endtask

    function automatic logic [15:0] expect_pix(input logic [15:0] c);
        logic [10:0] s;
        logic [8:0] q;
        s = (c > 16'h07FF) ? IDX_MAX : c[10:0];
        q = tbl[s];
        case ({en, fmt})
            3'h4: return {8'h00, q[8:1]};
            3'h5: return {4'h0, q, 3'h0};
            3'h6: return {q, 7'h00};
            3'h0: return {8'h00, s[10:3]};
            3'h1: return {4'h0, s, 1'b0};
            default: return {s, 5'h00};
        endcase
    endfunction

    task automatic pix(input logic [15:0] c);
        @(posedge ref_clk_i);
        send <= 1'b1;
        code <= c;
        exp_q.push_back(expect_pix(c));
    endtask

    task automatic pix_end();
        @(posedge ref_clk_i);
        send <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        `CHK(32'(exp_q.size()), 32'h0000_0000)
    endtask

    always @(posedge ref_clk_i) begin
        if (pix_valid_out === 1'b1) begin
            if (exp_q.size() == 0)
                `CHK(pix_valid_out, 1'b0)
            else begin
                // Pop once: the compare macro reads its argument twice
                exp_pix = exp_q.pop_front();
                `CHK(pix_out, exp_pix)
            end
        end
    end

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            num_errors++;
            conclude();
        end
    end

    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        send = 1'b0;
        code = 16'h0000;
        reset_model();
        repeat (8) @(posedge ref_clk_i);
        `CHK(hreadyout, 1'b1)
        `CHK(pix_valid_out, 1'b0)
        rst_i <= 1'b0;
        pix(16'h0400);
        pix_end();
        rd_chk(32'(OFF_STAT), 32'h0000_0000);
        rd_chk(32'(OFF_CTRL), 32'h0000_0000);
        wr(32'(OFF_SEL), 32'h0000_0001);
        rd_chk(32'(OFF_SEL), 32'(SEL_USER_ONE));
        for (int k = 0; k < 5; k++)
            rd_chk(32'h2000 + 32'(4 * pts[k]), 32'(pts[k] / 4));
        wr(32'h0000_4000, 32'h0000_0055);
        rd_chk(32'h0000_4000, 32'h0000_0000);
        wr(32'(OFF_IDX), 32'd1000);
        rd_chk(32'(OFF_IDX), 32'd1000);
        // Byte-sized writes must leave the index alone
        hsize <= 3'h0;
        wr(32'(OFF_IDX), 32'd5);
        hsize <= 3'h2;
        rd_chk(32'(OFF_IDX), 32'd1000);
        rd_chk(32'(OFF_VAL), 32'd250);
        wr(32'(OFF_IDX), 32'd2048);
        rd_chk(32'(OFF_IDX), 32'd1000);
        rd_chk(32'(OFF_STAT), 32'h0000_0001);
        wr(32'(OFF_STAT), 32'h0000_0001);
        rd_chk(32'(OFF_STAT), 32'h0000_0000);
        set_ctrl(1'b0, 2'h0);
        set_coef(1000, 9'h1AB, 1'b0);
        set_coef(7, 9'h155, 1'b1);
        wr(32'(OFF_IDX), 32'd7);
        rd_chk(32'(OFF_VAL), 32'h0000_0155);
        wr(32'h2000 + 32'd12, 32'hFFFF_FE01);
        tbl[3] = 9'h001;
        rd_chk(32'h2000 + 32'd12, 32'h0000_0001);
        for (int f = 0; f < 3; f++) begin
            set_ctrl(1'b0, 2'(f));
            pix(16'd1000);
            pix(16'hFFFF);
            pix_end();
            set_ctrl(1'b1, 2'(f));
            pix(16'd1000);
            pix(16'd7);
            pix(16'h0FFF);
            pix(16'd3);
            pix_end();
        end
        set_ctrl(1'b1, 2'h0);
        set_coef(1000, 9'h0F0, 1'b0);
        pix(16'd1000);
        pix_end();
        wr(32'(OFF_CTRL), 32'h0000_0007);
        rd_chk(32'(OFF_CTRL), 32'h0000_0001);
        rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        `CHK(hreadyout, 1'b1)
        rst_i <= 1'b0;
        reset_model();
        rd_chk(32'h2000 + 32'(4 * 1000), 32'd250);
        rd_chk(32'h2000 + 32'd28, 32'h0000_0001);
        rd_chk(32'(OFF_CTRL), 32'h0000_0000);
        conclude();
    end
endmodule
